//--- core/pwmc_consts.svh
// register map, field positions, reset values and unlock keys of the pin control block
`ifndef PWMC_CONSTS_SVH
`define PWMC_CONSTS_SVH

`define PWMC_OFF_PIN_CTRL 12'h000
`define PWMC_OFF_UNLOCK 12'h004
`define PWMC_OFF_STATUS 12'h008

`define PWMC_PIN_CTRL_RESET 16'hc000
`define PWMC_UNLOCK_KEY1 16'h0055
`define PWMC_UNLOCK_KEY2 16'h00aa

`define PWMC_BIT_OWN_HIGH 15
`define PWMC_BIT_OWN_LOW 14
`define PWMC_BIT_POL_HIGH 13
`define PWMC_BIT_POL_LOW 12
`define PWMC_MODE_HI 11
`define PWMC_MODE_LO 10
`define PWMC_BIT_OVR_EN_HIGH 9
`define PWMC_BIT_OVR_EN_LOW 8
`define PWMC_BIT_OVR_DATA_HIGH 7
`define PWMC_BIT_OVR_DATA_LOW 6
`define PWMC_BIT_FLT_DATA_HIGH 5
`define PWMC_BIT_FLT_DATA_LOW 4
`define PWMC_BIT_LIM_DATA_HIGH 3
`define PWMC_BIT_LIM_DATA_LOW 2
`define PWMC_BIT_SWAP 1
`define PWMC_BIT_OVERRIDE_SYNC_SELECT 0

`endif

//--- core/pwmc_pkg.sv
// types shared by the pin control block
package pwmc_pkg;

  typedef enum logic [1:0] {
    PWMC_MODE_COMPLEMENTARY = 2'b00,
    PWMC_MODE_REDUNDANT = 2'b01,
    PWMC_MODE_PUSH_PULL = 2'b10,
    PWMC_MODE_RESERVED = 2'b11
  } pwmc_mode_e;

  typedef enum logic [1:0] {
    PWMC_UNL_IDLE = 2'b00,
    PWMC_UNL_KEY1 = 2'b01,
    PWMC_UNL_OPEN = 2'b10
  } pwmc_unlock_e;

  typedef logic [15:0] pwmc_word_t;

endpackage

//--- core/pwmc_top.sv
// output pin control stage of one pwm generator pair, with apb register access
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "pwmc_consts.svh"

module pwmc_top #(
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic gen_high,
  input wire logic gen_low,
  input wire logic period_boundary,
  input wire logic fault_active,
  input wire logic limit_active,
  input wire logic module_timebase_enable,
  input wire logic write_lock_config,
  output logic high_side_output,
  output logic low_side_output,
  output logic high_side_owned,
  output logic low_side_owned
);
  import pwmc_pkg::*;

  // reset release through two flops
  logic rst_meta_reg;
  logic rst_n;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // apb decode
  logic [ADDR_W-1:0] off_ctrl;
  logic [ADDR_W-1:0] off_unlock;
  logic [ADDR_W-1:0] off_status;
  assign off_ctrl = ADDR_W'(`PWMC_OFF_PIN_CTRL);
  assign off_unlock = ADDR_W'(`PWMC_OFF_UNLOCK);
  assign off_status = ADDR_W'(`PWMC_OFF_STATUS);

  wire setup_phase = psel & ~penable;
  wire access_phase = psel & penable;
  wire hit_ctrl = (paddr == off_ctrl);
  wire hit_unlock = (paddr == off_unlock);
  wire hit_status = (paddr == off_status);
  wire mapped = hit_ctrl | hit_unlock | hit_status;
  wire wr_access = access_phase & pwrite;
  wire [15:0] wdata16 = pwdata[15:0];

  pwmc_word_t pin_ctrl_reg;
  pwmc_unlock_e unlock_reg;
  pwmc_unlock_e unlock_next;
  logic lock_cfg_reg;
  logic lock_seen_reg;

  // lock strap is caught once, after reset release
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_cfg_reg <= 1'b1;
      lock_seen_reg <= 1'b0;
    end else if (!lock_seen_reg) begin
      lock_cfg_reg <= write_lock_config;
      lock_seen_reg <= 1'b1;
    end
  end

  wire ctrl_open = ~lock_cfg_reg | (unlock_reg == PWMC_UNL_OPEN);
  wire ctrl_wr_try = wr_access & hit_ctrl;
  wire ctrl_wr_ok = ctrl_wr_try & ctrl_open;
  wire ctrl_wr_refused = ctrl_wr_try & ~ctrl_open;
  wire key_wr = wr_access & hit_unlock;

  // zero wait states: read data was loaded during setup
  assign pready = 1'b1;
  assign pslverr = access_phase & (~mapped | ctrl_wr_refused | (pwrite & hit_status));

  // unlock sequence: key1 then key2 on back-to-back writes opens one control write
  always_comb begin
    unlock_next = unlock_reg;
    unique case (unlock_reg)
      PWMC_UNL_IDLE: begin
        if (key_wr && wdata16 == `PWMC_UNLOCK_KEY1) begin
          unlock_next = PWMC_UNL_KEY1;
        end
      end
      PWMC_UNL_KEY1: begin
        if (key_wr && wdata16 == `PWMC_UNLOCK_KEY2) begin
          unlock_next = PWMC_UNL_OPEN;
        end else if (wr_access) begin
          unlock_next = PWMC_UNL_IDLE;
        end
      end
      PWMC_UNL_OPEN: begin
        // any write consumes the opening, used or not
        if (wr_access) begin
          unlock_next = PWMC_UNL_IDLE;
        end
      end
      default: begin
        unlock_next = PWMC_UNL_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      unlock_reg <= PWMC_UNL_IDLE;
    end else begin
      unlock_reg <= unlock_next;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_ctrl_reg <= `PWMC_PIN_CTRL_RESET;
    end else if (ctrl_wr_ok) begin
      pin_ctrl_reg <= wdata16;
    end
  end

  // control fields
  wire own_h = pin_ctrl_reg[`PWMC_BIT_OWN_HIGH];
  wire own_l = pin_ctrl_reg[`PWMC_BIT_OWN_LOW];
  wire pol_h = pin_ctrl_reg[`PWMC_BIT_POL_HIGH];
  wire pol_l = pin_ctrl_reg[`PWMC_BIT_POL_LOW];
  pwmc_mode_e mode;
  assign mode = pwmc_mode_e'(pin_ctrl_reg[`PWMC_MODE_HI:`PWMC_MODE_LO]);
  wire swap = pin_ctrl_reg[`PWMC_BIT_SWAP];
  wire override_sync_select = pin_ctrl_reg[`PWMC_BIT_OVERRIDE_SYNC_SELECT];
  wire [1:0] ovr_en_sw = pin_ctrl_reg[`PWMC_BIT_OVR_EN_HIGH:`PWMC_BIT_OVR_EN_LOW];
  wire [1:0] ovr_dat_sw = pin_ctrl_reg[`PWMC_BIT_OVR_DATA_HIGH:`PWMC_BIT_OVR_DATA_LOW];
  wire [1:0] flt_dat = pin_ctrl_reg[`PWMC_BIT_FLT_DATA_HIGH:`PWMC_BIT_FLT_DATA_LOW];
  wire [1:0] lim_dat = pin_ctrl_reg[`PWMC_BIT_LIM_DATA_HIGH:`PWMC_BIT_LIM_DATA_LOW];

  // override shadow, reloaded at period boundary when synchronised
  logic [1:0] ovr_en_sh_reg;
  logic [1:0] ovr_dat_sh_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovr_en_sh_reg <= 2'h0;
      ovr_dat_sh_reg <= 2'h0;
    end else if (!override_sync_select || period_boundary) begin
      ovr_en_sh_reg <= ovr_en_sw;
      ovr_dat_sh_reg <= ovr_dat_sw;
    end
  end

  // unsynchronised overrides bypass the shadow so they land one clock sooner
  wire [1:0] ovr_en = override_sync_select ? ovr_en_sh_reg : ovr_en_sw;
  wire [1:0] ovr_dat = override_sync_select ? ovr_dat_sh_reg : ovr_dat_sw;

  // low generator shaping by pin pair mode; reserved behaves as push-pull
  wire gen_l_mode = (mode == PWMC_MODE_COMPLEMENTARY) ? ~gen_high :
                    (mode == PWMC_MODE_REDUNDANT) ? gen_high : gen_low;

  wire route_h = swap ? gen_l_mode : gen_high;
  wire route_l = swap ? gen_high : gen_l_mode;

  // fault outranks current limit, which outranks override
  // trip levels come in as arguments: a continuous assignment wakes only on those
  function automatic logic pwmc_pick(input logic gen, input logic oe, input logic od,
                                     input logic fd, input logic ld, input logic fa,
                                     input logic la);
    logic v;
    v = gen;
    if (fa) begin
      v = fd;
    end else if (la) begin
      v = ld;
    end else if (oe) begin
      v = od;
    end
    return v;
  endfunction

  wire lvl_h = pwmc_pick(route_h, ovr_en[1], ovr_dat[1], flt_dat[1], lim_dat[1],
                         fault_active, limit_active);
  wire lvl_l = pwmc_pick(route_l, ovr_en[0], ovr_dat[0], flt_dat[0], lim_dat[0],
                         fault_active, limit_active);
  wire pin_h_next = lvl_h ^ pol_h;
  wire pin_l_next = lvl_l ^ pol_l;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      high_side_output <= 1'b0;
      low_side_output <= 1'b0;
      high_side_owned <= 1'b0;
      low_side_owned <= 1'b0;
    end else begin
      high_side_output <= pin_h_next;
      low_side_output <= pin_l_next;
      high_side_owned <= own_h;
      low_side_owned <= own_l;
    end
  end

  // status word
  wire [15:0] status_word = {8'h00, module_timebase_enable, lock_cfg_reg,
                             unlock_reg == PWMC_UNL_OPEN, ovr_en_sh_reg, ovr_dat_sh_reg[1],
                             high_side_output, low_side_output};

  wire [15:0] rd_sel = hit_ctrl ? pin_ctrl_reg :
                       hit_status ? status_word : 16'h0000;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (setup_phase) begin
      prdata <= {16'h0000, rd_sel};
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  wire quiet = ~fault_active & ~limit_active & ~mode[1] & ~mode[0];

  swap_route_a: assert property (
    (quiet & swap & ~ovr_en[1] & ~pol_h) |=> high_side_output == $past(~gen_high))
    else $error("swapped high pin does not carry low generator");

  straight_route_a: assert property (
    (~fault_active & ~limit_active & ~swap & ~ovr_en[1] & ~pol_h)
    |=> high_side_output == $past(gen_high))
    else $error("unswapped high pin does not carry high generator");

  sync_hold_a: assert property (
    (override_sync_select & ~period_boundary) |=> $stable(ovr_dat_sh_reg) && $stable(ovr_en_sh_reg))
    else $error("synchronised override moved off the period boundary");

  sync_load_a: assert property (
    (override_sync_select & period_boundary) |=> ovr_dat_sh_reg == $past(ovr_dat_sw))
    else $error("synchronised override not loaded at period boundary");

  async_apply_a: assert property (
    (ctrl_wr_ok & ~wdata16[`PWMC_BIT_OVERRIDE_SYNC_SELECT] & wdata16[`PWMC_BIT_OVR_EN_HIGH]
     & ~wdata16[`PWMC_BIT_POL_HIGH] & ~fault_active & ~limit_active)
    ##1 (~fault_active & ~limit_active)
    |=> high_side_output == $past(pin_ctrl_reg[`PWMC_BIT_OVR_DATA_HIGH]))
    else $error("immediate override not on pin next clock");

  lock_block_a: assert property (
    ctrl_wr_refused |=> $stable(pin_ctrl_reg))
    else $error("locked control register took a write");

  sequence key_pair_s;
    (key_wr && wdata16 == `PWMC_UNLOCK_KEY1) ##[1:8]
    (key_wr && wdata16 == `PWMC_UNLOCK_KEY2 && unlock_reg == PWMC_UNL_KEY1);
  endsequence

  unlock_open_a: assert property (
    key_pair_s |=> ctrl_open)
    else $error("unlock sequence did not open the control register");

  fault_force_a: assert property (
    fault_active |=> high_side_output == $past(flt_dat[1] ^ pol_h)
                     && low_side_output == $past(flt_dat[0] ^ pol_l))
    else $error("fault data not driven on pins");

  limit_force_a: assert property (
    (~fault_active & limit_active) |=> low_side_output == $past(lim_dat[0] ^ pol_l))
    else $error("limit data not driven on low pin");

  limit_high_a: assert property (
    (~fault_active & limit_active) |=> high_side_output == $past(lim_dat[1] ^ pol_h))
    else $error("limit data not driven on high pin");

  swap_low_a: assert property (
    (~fault_active & ~limit_active & swap & ~ovr_en[0] & ~pol_l)
    |=> low_side_output == $past(gen_high))
    else $error("swapped low pin does not carry high generator");

  straight_low_a: assert property (
    (quiet & ~swap & ~ovr_en[0] & ~pol_l) |=> low_side_output == $past(~gen_high))
    else $error("unswapped low pin does not carry shaped low generator");

  ovr_drive_a: assert property (
    (~fault_active & ~limit_active & ovr_en[1])
    |=> high_side_output == $past(ovr_dat[1] ^ pol_h))
    else $error("enabled override data not on high pin");

  // an opening must never outlive the write that follows it
  unlock_close_a: assert property (
    (unlock_reg == PWMC_UNL_OPEN && wr_access) |=> unlock_reg == PWMC_UNL_IDLE)
    else $error("unlock opening survived a write");

endmodule

//--- testbench/pwmc_gate_model.sv
// behavioural gate driver pair on the two output pins, reporting trips back
`timescale 1ns/1ps
module pwmc_gate_model (
  input wire logic ref_clk,
  input wire logic high_gate,
  input wire logic low_gate,
  input wire logic trip_fault,
  input wire logic trip_limit,
  output logic fault_active = 1'b0,
  output logic limit_active = 1'b0,
  output logic [1:0] gate_state = 2'b00
);
  // trip flags are registered, as a real driver reports one clock late
  always @(posedge ref_clk) begin
    fault_active <= trip_fault;
    limit_active <= trip_limit;
    gate_state <= {high_gate, low_gate};
  end
endmodule

//--- testbench/pwmc_top_bench.sv
// self-checking bench of the pin control block
`timescale 1ns/1ps
`include "pwmc_consts.svh"
module pwmc_top_bench;
  typedef struct {logic [15:0] ctl; logic gh, gl, flt, lim, eh, el;} pwmc_row_s;
  logic ref_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e, gh = 1'b0, gl = 1'b0, pb = 1'b0, tf = 1'b0, tl = 1'b0;
  logic ten = 1'b0, wl = 1'b1, fa, la, hp, lp, ho, lo;
  int n_fail = 0, samples_checked = 0;
  pwmc_row_s rows [10] = '{
    '{16'hc000, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0},
    '{16'hc000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1},
    '{16'hc002, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1},
    '{16'hc400, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1},
    '{16'hc800, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0},
    '{16'hc802, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1},
    '{16'hc880, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1},
    '{16'hcb80, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0},
    '{16'hc818, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1},
    '{16'hf808, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1}};
  pwmc_top DUT (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gen_high(gh), .gen_low(gl), .period_boundary(pb),
    .fault_active(fa), .limit_active(la), .module_timebase_enable(ten),
    .write_lock_config(wl), .high_side_output(hp), .low_side_output(lp),
    .high_side_owned(ho), .low_side_owned(lo));
  pwmc_gate_model drv (.ref_clk(ref_clk), .high_gate(hp), .low_gate(lp),
    .trip_fault(tf), .trip_limit(tl), .fault_active(fa), .limit_active(la),
    .gate_state());
  initial forever #2.5 ref_clk = ~ref_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // only the watchdog ends a wait for pready
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // the lock strap is tied set, so every control write opens the lock first
  task automatic wctl(input logic [15:0] v);
    apb(1'b1, `PWMC_OFF_UNLOCK, {16'h0, `PWMC_UNLOCK_KEY1});
    apb(1'b1, `PWMC_OFF_UNLOCK, {16'h0, `PWMC_UNLOCK_KEY2});
    apb(1'b1, `PWMC_OFF_PIN_CTRL, {16'h0, v});
    chk({31'h0, e}, 32'h0);
  endtask
  task automatic give_verdict;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #(20000 * 5);
    n_fail++;
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk({30'h0, ho, lo}, 32'h3);
    apb(1'b0, `PWMC_OFF_PIN_CTRL, 32'h0);
    chk(q, {16'h0, `PWMC_PIN_CTRL_RESET});
    // locked write without keys must be refused and leave the register alone
    apb(1'b1, `PWMC_OFF_PIN_CTRL, 32'h0000_0802);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, `PWMC_OFF_PIN_CTRL, 32'h0);
    chk(q, {16'h0, `PWMC_PIN_CTRL_RESET});
    // pair mode changes in the table below run with the timebase stopped
    ten <= 1'b0;
    foreach (rows[i]) begin
      gh <= rows[i].gh;
      gl <= rows[i].gl;
      tf <= rows[i].flt;
      tl <= rows[i].lim;
      wctl(rows[i].ctl);
      repeat (3) @(posedge ref_clk);
      chk({28'h0, hp, lp, ho, lo}, {28'h0, rows[i].eh, rows[i].el, 2'b11});
    end
    tf <= 1'b0;
    tl <= 1'b0;
    gh <= 1'b0;
    gl <= 1'b0;
    wctl(16'hc800);
    repeat (3) @(posedge ref_clk);
    chk({30'h0, hp, lp}, 32'h0);
    wctl(16'hcb81);
    repeat (6) @(posedge ref_clk);
    chk({30'h0, hp, lp}, 32'h0);
    pb <= 1'b1;
    @(posedge ref_clk);
    pb <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk({30'h0, hp, lp}, 32'h2);
    apb(1'b0, 12'h00c, 32'h0);
    chk({q[30:0], e}, 32'h1);
    ten <= 1'b1;
    apb(1'b0, `PWMC_OFF_STATUS, 32'h0);
    chk({30'h0, q[7:6]}, 32'h3);
    // second reset with the strap clear: control writes then need no keys
    wl <= 1'b0;
    resetn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk(prdata, 32'h0);
    chk({27'h0, pready, hp, lp, ho, lo}, 32'h10);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    apb(1'b1, `PWMC_OFF_PIN_CTRL, 32'h0000_c802);
    chk({31'h0, e}, 32'h0);
    apb(1'b0, `PWMC_OFF_PIN_CTRL, 32'h0);
    chk(q, 32'h0000_c802);
    give_verdict();
  end
endmodule
